// ---- logic/realtime_down_counter_capture.sv ----
// Function
// R1: one 48-bit counter counts down synchronously on the selected source.
// R2: capture command copies the counter into a capture register, counting continues.
// R3: capture register then moves into the transfer register the host reads.
// R4: transfer register does not change while a host read is in progress.
// R5: captured value is read as three consecutive 16-bit words.
// R6: counter load also forces a capture, discarding stale data.
// R7: counter at zero raises preset-reached.
// R8: with preset halt enabled the counter stops at zero.
// R9: when selected, reaching zero pulls the run line to stop.
// R10: run line is open-drain wired-AND; everyone follows its level.
// R11: software sets and resets its own run line drive directly.
// R12: a preset of zero loads the maximum count.
// R13: 20 MHz source steps the counter every 50 ns from the core clock.
// R14: reload by aux holds counter reloaded while aux active, free otherwise.
// R15: lock releases after third word, pending capture then applied.
// R16: counter load puts preset in counter and clears preset-reached.
`timescale 1ns/1ns
`include "rtc_timer_regs.svh"
module realtime_down_counter_capture
  import rtc_timer_pkg::*;
#(
  parameter int STEP_CYC = `RTC_STEP_CYC
) (
  input  wire logic                  core_clk,      // 100 MHz core clock
  input  wire logic                  rst,           // synchronous reset, active high
  input  wire rtcCfg_t               cfg,           // configuration
  input  wire logic                  timerLoad,     // load preset, one-cycle pulse
  input  wire logic                  captureCmd,    // capture request, one-cycle pulse
  input  wire logic                  extTick,       // external count source pin
  input  wire logic                  auxIn,         // auxiliary reload pin
  input  wire logic                  runSet,        // software: release run line
  input  wire logic                  runClear,      // software: pull run line low
  input  wire logic                  runLineIn,     // run line level (pin)
  input  wire logic                  readStrobe,    // host reads one 16-bit word
  output logic [`RTC_WORD_W-1:0]     readData,      // word presented to host
  output logic [1:0]                 readIndex,     // index of the next word
  output logic                       readLocked,    // transfer register locked
  output logic                       presetReached, // counter reached zero
  output logic                       runOut,        // run line output value (always 0)
  output logic                       runOe_n,       // low while pulling run line low
  output logic                       running,       // synchronised run line level
  output logic [`RTC_CNT_W-1:0]      count          // live counter value
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // only the second stage of each synchroniser feeds logic
  logic [1:0] extSync;
  logic [1:0] auxSync;
  logic [1:0] runSync;
  logic       extPrev;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      extSync <= 2'h0;
      auxSync <= 2'h0;
      runSync <= 2'h0;
      extPrev <= 1'b0;
    end else begin
      extSync <= {extSync[0], extTick};
      auxSync <= {auxSync[0], auxIn};
      runSync <= {runSync[0], runLineIn};
      extPrev <= extSync[1];
    end
  end

  // ----------------------------------------------------------------
  // count step selection
  // ----------------------------------------------------------------
  // the divider runs free, so a load does not shift the step grid
  logic [7:0] divCnt;
  wire        divWrap  = (divCnt == 8'(STEP_CYC - 1));
  // each rising edge of the external pin counts one step
  wire        extEdge  = extSync[1] & ~extPrev;
  wire        stepSrc  = (cfg.source == SRC_20MHZ) ? divWrap :   // [R13]
                         (cfg.source == SRC_EXT)   ? extEdge : 1'b0;
  // aux reload holds the count at the preset for every cycle it is active
  wire        auxActive = cfg.reloadByAux & (auxSync[1] == cfg.auxActiveHigh);
  wire        loadNow  = timerLoad | auxActive;                   // [R14]
  wire        atZero   = (count == `RTC_CNT_ZERO);
  wire        halted   = cfg.haltAtZero & atZero;                  // [R8]
  // a low run line freezes the count: all participants stop together
  wire        step     = stepSrc & runSync[1] & ~halted;           // [R10]
  // a zero preset stands for the full 48-bit range
  wire [`RTC_CNT_W-1:0] loadValue =
    (cfg.preset == `RTC_CNT_ZERO) ? `RTC_CNT_MAX : cfg.preset;     // [R12]

  always_ff @(posedge core_clk) begin
    if (rst) divCnt <= 8'h00;
    else if (divWrap) divCnt <= 8'h00;
    else divCnt <= divCnt + 8'h01;
  end

  // ----------------------------------------------------------------
  // down counter and preset flag
  // ----------------------------------------------------------------
  // a load has priority over counting in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      count <= `RTC_CNT_MAX;
    end else if (loadNow) begin
      count <= loadValue;                                          // [R16]
    end else if (step) begin
      count <= count - 48'h000000000001;                           // [R1]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) presetReached <= 1'b0;
    else if (loadNow) presetReached <= 1'b0;                       // [R16]
    else if (atZero) presetReached <= 1'b1;                        // [R7]
  end

  // ----------------------------------------------------------------
  // run line drive
  // ----------------------------------------------------------------
  logic runHold;
  wire  zeroStop = cfg.stopRunAtZero & atZero & ~loadNow;
  // a zero stop or a software pull wins over a release in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) runHold <= 1'b0;
    else if (zeroStop) runHold <= 1'b1;                            // [R9]
    else if (runClear) runHold <= 1'b1;                            // [R11]
    else if (runSet) runHold <= 1'b0;                              // [R11]
  end

  // runOut stays 0: the shared line is only ever pulled low or let go
  always_ff @(posedge core_clk) begin
    if (rst) begin
      runOut  <= 1'b0;
      runOe_n <= 1'b1;
      running <= 1'b0;
    end else begin
      runOut  <= 1'b0;
      runOe_n <= ~(runHold | zeroStop);                            // [R10]
      running <= runSync[1];
    end
  end

  // ----------------------------------------------------------------
  // capture pipeline and read lock
  // ----------------------------------------------------------------
  logic [`RTC_CNT_W-1:0] captureReg;
  logic [`RTC_CNT_W-1:0] transferReg;
  logic                  pending;
  rdState_t              rdState;
  wire                   doCapture = captureCmd | timerLoad;       // [R6]
  wire                   lastWord  = readStrobe & (readIndex == 2'(`RTC_WORDS - 1));
  wire                   canMove   = (rdState == RD_IDLE) & ~readStrobe;
  // a load captures the value that starts the new timer cycle
  wire [`RTC_CNT_W-1:0]  captureSrc = timerLoad ? loadValue : count; // [R6]
  // the lock sets on the first strobe and releases on the third
  wire                   next_readLocked = (rdState == RD_IDLE) ? readStrobe : ~lastWord;

  always_ff @(posedge core_clk) begin
    if (rst) captureReg <= `RTC_CNT_ZERO;
    else if (doCapture) captureReg <= captureSrc;                  // [R2]
  end

  // a capture that meets the lock waits in pending; the newest one wins

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pending     <= 1'b0;
      transferReg <= `RTC_CNT_ZERO;
    end else if (pending & canMove) begin
      transferReg <= captureReg;                                   // [R3] [R15]
      pending     <= doCapture;
    end else if (doCapture) begin
      pending     <= 1'b1;                                         // [R4]
    end
  end

  // readIndex counts the words taken in the current read
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdState   <= RD_IDLE;
      readIndex <= 2'h0;
    end else begin
      case (rdState)
        RD_IDLE: begin
          if (readStrobe) begin
            rdState   <= RD_BUSY;                                  // [R4]
            readIndex <= 2'h1;
          end
        end
        RD_BUSY: begin
          if (lastWord) begin
            rdState   <= RD_IDLE;                                  // [R15]
            readIndex <= 2'h0;
          end else if (readStrobe) begin
            readIndex <= readIndex + 2'h1;                         // [R5]
          end
        end
        default: begin
          rdState   <= RD_IDLE;
          readIndex <= 2'h0;
        end
      endcase
    end
  end

  // one 16-bit word of a captured value, lowest word first
  function automatic logic [`RTC_WORD_W-1:0] wordSel(input logic [`RTC_CNT_W-1:0] v,
                                                     input logic [1:0]             idx);
    if (idx == 2'h0) return v[15:0];
    else if (idx == 2'h1) return v[31:16];
    else return v[47:32];
  endfunction : wordSel

  // readData shows the word for the next strobe, one edge after each change
  wire [1:0] nextIndex = (rdState == RD_IDLE) ? 2'h0 : readIndex;
  wire [`RTC_WORD_W-1:0] next_readData = wordSel(transferReg, nextIndex); // [R5]

  always_ff @(posedge core_clk) begin
    if (rst) begin
      readData   <= 16'h0000;
      readLocked <= 1'b0;
    end else begin
      readData   <= next_readData;
      readLocked <= next_readLocked;                               // [R4]
    end
  end
endmodule : realtime_down_counter_capture

// ---- logic/rtc_timer_regs.svh ----
`ifndef RTC_TIMER_REGS_SVH
`define RTC_TIMER_REGS_SVH
// ----------------------------------------------------------------
// widths and constants
// ----------------------------------------------------------------
`define RTC_CNT_W        48
`define RTC_WORD_W       16
`define RTC_WORDS        3
`define RTC_CNT_MAX      48'hFFFFFFFFFFFF
`define RTC_CNT_ZERO     48'h000000000000
`define RTC_STEP_NS      50
`define RTC_CLK_NS       10
// core clock cycles per 50 ns count step of the 20 MHz source
`define RTC_STEP_CYC     (`RTC_STEP_NS / `RTC_CLK_NS)
`endif

// ---- logic/rtc_timer_pkg.sv ----
package rtc_timer_pkg;
  `include "rtc_timer_regs.svh"

  typedef enum logic [1:0] {
    SRC_20MHZ = 2'h0,
    SRC_EXT   = 2'h1,
    SRC_OFF   = 2'h2
  } cntSrc_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h1,
    RD_BUSY = 2'h2
  } rdState_t;

  typedef struct packed {
    cntSrc_t                 source;
    logic                    haltAtZero;
    logic                    stopRunAtZero;
    logic                    reloadByAux;
    logic                    auxActiveHigh;
    logic [`RTC_CNT_W-1:0]   preset;
  } rtcCfg_t;
endpackage : rtc_timer_pkg

// ---- bench/rtc_timer_asserts.sv ----
`timescale 1ns/1ns
module rtc_timer_asserts
  import rtc_timer_pkg::*;
(
  input wire logic        core_clk,      // clock
  input wire logic        rst,           // reset
  input wire rtcCfg_t     cfg,           // configuration
  input wire logic        timerLoad,     // load pulse
  input wire logic        runSet,        // release run line
  input wire logic        runClear,      // pull run line
  input wire logic        readStrobe,    // word taken
  input wire logic [15:0] readData,      // word shown
  input wire logic [1:0]  readIndex,     // words taken
  input wire logic        readLocked,    // read lock
  input wire logic        presetReached, // zero flag
  input wire logic        runOut,        // run line value
  input wire logic        runOe_n,       // run line enable
  input wire logic [47:0] count          // counter
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_load; timerLoad && cfg.preset != 48'h0 |=> count == $past(cfg.preset); endproperty
  a_load: assert property (p_load) else $error("load value wrong");
  property p_zmax; timerLoad && cfg.preset == 48'h0 |=> count == 48'hFFFFFFFFFFFF; endproperty
  a_zmax: assert property (p_zmax) else $error("zero preset not max");
  property p_flag; count == 48'h0 && !timerLoad && !cfg.reloadByAux |=> presetReached; endproperty
  a_flag: assert property (p_flag) else $error("flag missing at zero");
  property p_halt;
    cfg.haltAtZero && !cfg.reloadByAux && !timerLoad && count == 48'h0 |=> count == 48'h0;
  endproperty
  a_halt: assert property (p_halt) else $error("counter left zero");
  property p_lock; readLocked && !readStrobe && !$past(readStrobe) |=> $stable(readData); endproperty
  a_lock: assert property (p_lock) else $error("word moved while locked");
  property p_first; readStrobe && readIndex == 2'h0 |=> readLocked && readIndex == 2'h1; endproperty
  a_first: assert property (p_first) else $error("first word not locked");
  property p_last; readStrobe && readIndex == 2'h2 |=> !readLocked && readIndex == 2'h0; endproperty
  a_last: assert property (p_last) else $error("lock kept after third word");
  property p_zrun;
    cfg.stopRunAtZero && !cfg.reloadByAux && count == 48'h0 && !timerLoad |-> ##[1:3] !runOe_n;
  endproperty
  a_zrun: assert property (p_zrun) else $error("run line not pulled at zero");
  property p_clr; runClear |-> ##2 (!runOe_n && !runOut); endproperty
  a_clr: assert property (p_clr) else $error("run line not pulled");
  c_read: cover property (readStrobe && readIndex == 2'h2);
  c_zero: cover property (presetReached && !runOe_n);
  c_pend: cover property (readLocked && timerLoad);
endmodule : rtc_timer_asserts
bind realtime_down_counter_capture rtc_timer_asserts u_chk (
  .core_clk(core_clk), .rst(rst), .cfg(cfg), .timerLoad(timerLoad), .runSet(runSet),
  .runClear(runClear), .readStrobe(readStrobe), .readData(readData), .readIndex(readIndex),
  .readLocked(readLocked), .presetReached(presetReached), .runOut(runOut),
  .runOe_n(runOe_n), .count(count));

// ---- bench/host_reader.sv ----
`timescale 1ns/1ns
module host_reader (
  input  wire logic        core_clk,  // core clock
  input  wire logic [15:0] readData,  // word shown by the block
  output logic             readStrobe // one word taken
);
  initial readStrobe = 1'b0;
  // one word: let the word settle, take it, strobe for one edge
  task word(output logic [15:0] w);
    @(negedge core_clk);
    @(negedge core_clk);
    w = readData;
    readStrobe = 1'b1;
    @(negedge core_clk);
    readStrobe = 1'b0;
  endtask : word
  task get(output logic [47:0] v);
    repeat (3) @(negedge core_clk);
    word(v[15:0]);
    word(v[31:16]);
    word(v[47:32]);
  endtask : get
endmodule : host_reader

// ---- bench/tb.sv ----
`timescale 1ns/1ns
module tb
  import rtc_timer_pkg::*;
;
  localparam int STEP = 5; // core cycles per 50 ns count step
  typedef struct packed { logic [47:0] p; logic [47:0] e; } row_t;
  row_t rows [3] = '{'{48'h0, 48'hFFFFFFFFFFFF}, '{48'h123456789ABC, 48'h123456789ABC},
                     '{48'h1, 48'h1}};
  logic core_clk, rst, timerLoad, captureCmd, auxIn, runSet, runClear, readStrobe, otherLow;
  logic readLocked, presetReached, runOut, runOe_n, running;
  logic extTick;
  logic [15:0] readData, w0, w1, w2;
  logic [1:0]  readIndex;
  logic [47:0] count, v, c0;
  rtcCfg_t     cfg;
  int          fail_count, check_count;
  // pulled-up wired-AND run line, another party may hold it low
  wire runLine = ~otherLow & (runOe_n | runOut);
  realtime_down_counter_capture #(.STEP_CYC(STEP)) u_realtime_down_counter_capture (
    .core_clk(core_clk), .rst(rst), .cfg(cfg), .timerLoad(timerLoad), .captureCmd(captureCmd),
    .extTick(extTick), .auxIn(auxIn), .runSet(runSet), .runClear(runClear), .runLineIn(runLine),
    .readStrobe(readStrobe), .readData(readData), .readIndex(readIndex), .readLocked(readLocked),
    .presetReached(presetReached), .runOut(runOut), .runOe_n(runOe_n), .running(running),
    .count(count));
  host_reader u_host_reader (.core_clk(core_clk), .readData(readData), .readStrobe(readStrobe));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task chk(input logic [47:0] got, input logic [47:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task load(input logic [47:0] p);
    cfg.preset = p;
    timerLoad = 1'b1;
    @(negedge core_clk) timerLoad = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask : load
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (3000) @(posedge core_clk);
    fail_count++;
    give_verdict();
  end
  initial begin
    {timerLoad, captureCmd, auxIn, runSet, runClear, otherLow, extTick} = '0;
    rst = 1'b1;
    cfg = '{SRC_20MHZ, 1'b0, 1'b0, 1'b0, 1'b1, 48'h0};
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    chk(count, 48'hFFFFFFFFFFFF, "reset count");
    runClear = 1'b1;
    @(negedge core_clk) runClear = 1'b0;
    repeat (4) @(negedge core_clk);
    chk(48'(runOe_n), 48'h0, "run line not pulled");
    foreach (rows[i]) begin
      load(rows[i].p);
      chk(count, rows[i].e, "loaded count");
      u_host_reader.get(v);
      chk(v, rows[i].e, "captured value");
    end
    captureCmd = 1'b1;
    @(negedge core_clk) captureCmd = 1'b0;
    u_host_reader.get(v);
    chk(v, 48'h1, "plain capture");
    load(48'hA5A5A5A5A5A5);
    u_host_reader.word(w0);
    @(negedge core_clk);
    load(48'h5A5A5A5A5A5A);
    u_host_reader.word(w1);
    u_host_reader.word(w2);
    chk({w2, w1, w0}, 48'hA5A5A5A5A5A5, "value changed while locked");
    u_host_reader.get(v);
    chk(v, 48'h5A5A5A5A5A5A, "pending capture lost");
    runSet = 1'b1;
    @(negedge core_clk) runSet = 1'b0;
    c0 = count;
    for (int i = 0; i < 50 && count === c0; i++) @(negedge core_clk);
    c0 = count;
    repeat (10 * STEP) @(negedge core_clk);
    chk(count, c0 - 48'hA, "step rate");
    otherLow = 1'b1;
    repeat (5) @(negedge core_clk);
    c0 = count;
    repeat (10) @(negedge core_clk);
    chk(count, c0, "ran with run line low");
    chk(48'(running), 48'h0, "run level not followed");
    otherLow = 1'b0;
    cfg.reloadByAux = 1'b1;
    auxIn = 1'b1;
    repeat (8) @(negedge core_clk);
    chk(count, 48'h5A5A5A5A5A5A, "aux reload");
    auxIn = 1'b0;
    repeat (8) @(negedge core_clk);
    cfg.reloadByAux = 1'b0;
    chk(48'(count < 48'h5A5A5A5A5A5A), 48'h1, "aux free run");
    cfg.haltAtZero = 1'b1;
    cfg.stopRunAtZero = 1'b1;
    load(48'h3);
    repeat (20) @(negedge core_clk);
    chk(48'({count == 48'h0, presetReached, runOe_n}), 48'h6, "zero stop");
    cfg.haltAtZero = 1'b0;
    cfg.stopRunAtZero = 1'b0;
    runSet = 1'b1;
    @(negedge core_clk) runSet = 1'b0;
    repeat (2) @(negedge core_clk);
    chk(48'(runOe_n), 48'h1, "run line not released");
    load(48'h3);
    chk(48'(presetReached), 48'h0, "flag not cleared");
    repeat (20) @(negedge core_clk);
    chk(48'(count[47]), 48'h1, "counter stuck at zero");
    cfg.source = SRC_EXT;
    c0 = count;
    repeat (4) begin
      extTick = 1'b1;
      repeat (3) @(negedge core_clk);
      extTick = 1'b0;
      repeat (3) @(negedge core_clk);
    end
    chk(count, c0 - 48'h4, "external edges");
    cfg.source = SRC_OFF;
    c0 = count;
    extTick = 1'b1;
    repeat (8) @(negedge core_clk);
    chk(count, c0, "counted with source off");
    give_verdict();
  end
endmodule : tb
